// ==== twoc_map.vh ====
`ifndef TWOC_MAP_VH
`define TWOC_MAP_VH
// Register offsets on the plain register port
`define TWOC_OFS_CTRL_A 4'h0
`define TWOC_OFS_CTRL_B 4'h1
`define TWOC_OFS_CNT 4'h2
`define TWOC_OFS_CMP_A 4'h3
`define TWOC_OFS_CMP_B 4'h4
`define TWOC_OFS_STATUS 4'h5
// Field positions in control register A
`define TWOC_A_ACT_HI 7
`define TWOC_A_ACT_LO 6
`define TWOC_B_ACT_HI 5
`define TWOC_B_ACT_LO 4
`define TWOC_WM_HI 1
`define TWOC_WM_LO 0
// Field position in control register B
`define TWOC_WM_TOP_BIT 3
// Reset values
`define TWOC_RST_CTRL_A 8'h00
`define TWOC_RST_CTRL_B 8'h00
`define TWOC_RST_BYTE 8'h00
// Counter landmarks
`define TWOC_MAX 8'hff
`define TWOC_BOTTOM 8'h00
// Mode codes
`define TWOC_M_NORMAL 3'h0
`define TWOC_M_PC_FF 3'h1
`define TWOC_M_CTC 3'h2
`define TWOC_M_FAST_FF 3'h3
`define TWOC_M_PC_OCA 3'h5
`define TWOC_M_FAST_OCA 3'h7
`endif

// ==== twoc_mode_decode.v ====
`timescale 1ns/10ps
`default_nettype none
`include "twoc_map.vh"
// Decodes the three-bit waveform mode into its properties
module twoc_mode_decode (
   input wire [2:0] mode,
   output reg is_pwm,
   output reg is_fast,
   output reg is_phase,
   output reg top_is_cmp_a,
   output reg upd_immediate,
   output reg upd_at_bottom,
   output reg ovf_at_max,
   output reg ovf_at_top,
   output reg ovf_at_bottom
);
   // Mode table lookup
   always @* begin
      is_pwm = 1'b0;
      is_fast = 1'b0;
      is_phase = 1'b0;
      top_is_cmp_a = 1'b0;
      upd_immediate = 1'b0;
      upd_at_bottom = 1'b0;
      ovf_at_max = 1'b0;
      ovf_at_top = 1'b0;
      ovf_at_bottom = 1'b0;
      case (mode)
         `TWOC_M_NORMAL: begin
            upd_immediate = 1'b1;
            ovf_at_max = 1'b1;
         end
         `TWOC_M_CTC: begin
            top_is_cmp_a = 1'b1;
            upd_immediate = 1'b1;
            ovf_at_max = 1'b1;
         end
         `TWOC_M_PC_FF, `TWOC_M_PC_OCA: begin
            is_pwm = 1'b1;
            is_phase = 1'b1;
            top_is_cmp_a = mode[2];
            ovf_at_bottom = 1'b1;
         end
         `TWOC_M_FAST_FF: begin
            is_pwm = 1'b1;
            is_fast = 1'b1;
            upd_at_bottom = 1'b1;
            ovf_at_max = 1'b1;
         end
         `TWOC_M_FAST_OCA: begin
            is_pwm = 1'b1;
            is_fast = 1'b1;
            top_is_cmp_a = 1'b1;
            upd_at_bottom = 1'b1;
            ovf_at_top = 1'b1;
         end
         default: begin
            // Reserved modes 4 and 6: counter holds, no update
            upd_immediate = 1'b0;
         end
      endcase
   end
endmodule // twoc_mode_decode
`default_nettype wire

// ==== twoc_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "twoc_map.vh"
module twoc_top (
   input wire clk,
   input wire reset_n,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire count_tick,
   output reg [7:0] reg_rdata,
   output wire compare_out_a,
   output wire compare_out_a_sel,
   output wire compare_out_b,
   output wire compare_out_b_sel,
   output reg overflow_pulse_r
);
   reg [7:0] ctrl_a_r;
   reg wave_mode_high_bit_r;
   reg [7:0] count_r;
   reg [7:0] cmp_buf_a_r;
   reg [7:0] cmp_buf_b_r;
   reg [7:0] compare_value_a_r;
   reg [7:0] compare_value_b_r;
   reg counting_up_r;
   reg overflow_flag_r;
   reg match_a_r;
   reg match_b_r;
   reg [7:0] rdata_nxt;
   wire [1:0] chan_a_output_action;
   wire [1:0] chan_b_output_action;
   wire [2:0] wave_mode_field;
   wire is_pwm, is_fast, is_phase, top_is_cmp_a;
   wire upd_immediate, upd_at_bottom, ovf_at_max, ovf_at_top, ovf_at_bottom;
   wire [7:0] top_val;
   wire at_top, at_bottom, at_max, ovf_evt, wr_cnt;
   wire reserved_mode;

   // Write-enable decode
   function wr_hit;
      input [3:0] a;
      input [3:0] ofs;
      begin
         wr_hit = reg_wr && (a == ofs);
      end
   endfunction

   assign chan_a_output_action = ctrl_a_r[`TWOC_A_ACT_HI:`TWOC_A_ACT_LO];
   assign chan_b_output_action = ctrl_a_r[`TWOC_B_ACT_HI:`TWOC_B_ACT_LO];
   // Three-bit mode from both control registers
   assign wave_mode_field = {wave_mode_high_bit_r, ctrl_a_r[`TWOC_WM_HI:`TWOC_WM_LO]};

   twoc_mode_decode u_dec (
      .mode(wave_mode_field),
      .is_pwm(is_pwm),
      .is_fast(is_fast),
      .is_phase(is_phase),
      .top_is_cmp_a(top_is_cmp_a),
      .upd_immediate(upd_immediate),
      .upd_at_bottom(upd_at_bottom),
      .ovf_at_max(ovf_at_max),
      .ovf_at_top(ovf_at_top),
      .ovf_at_bottom(ovf_at_bottom)
   );

   // Counter landmarks
   assign reserved_mode = (wave_mode_field == 3'h4) || (wave_mode_field == 3'h6);
   assign top_val = top_is_cmp_a ? compare_value_a_r : `TWOC_MAX;
   assign at_top = (count_r == top_val);
   assign at_bottom = (count_r == `TWOC_BOTTOM);
   assign at_max = (count_r == `TWOC_MAX);
   assign wr_cnt = wr_hit(reg_addr, `TWOC_OFS_CNT);

   // Overflow event by mode
   assign ovf_evt = count_tick && !reserved_mode &&
      ((ovf_at_max && at_max) || (ovf_at_top && at_top) ||
       (ovf_at_bottom && at_bottom && !counting_up_r));

   // Control registers and compare buffers
   always @(posedge clk) begin
      if (!reset_n) begin
         ctrl_a_r <= `TWOC_RST_CTRL_A;
         wave_mode_high_bit_r <= 1'b0;
         cmp_buf_a_r <= `TWOC_RST_BYTE;
         cmp_buf_b_r <= `TWOC_RST_BYTE;
      end else begin
         if (wr_hit(reg_addr, `TWOC_OFS_CTRL_A))
            ctrl_a_r <= {reg_wdata[7:4], 2'b00, reg_wdata[1:0]};
         if (wr_hit(reg_addr, `TWOC_OFS_CTRL_B))
            wave_mode_high_bit_r <= reg_wdata[`TWOC_WM_TOP_BIT];
         if (wr_hit(reg_addr, `TWOC_OFS_CMP_A))
            cmp_buf_a_r <= reg_wdata;
         if (wr_hit(reg_addr, `TWOC_OFS_CMP_B))
            cmp_buf_b_r <= reg_wdata;
      end
   end

   // Active compare values, updated per mode
   always @(posedge clk) begin
      if (!reset_n) begin
         compare_value_a_r <= `TWOC_RST_BYTE;
         compare_value_b_r <= `TWOC_RST_BYTE;
      end else if (upd_immediate) begin
         compare_value_a_r <= wr_hit(reg_addr, `TWOC_OFS_CMP_A) ? reg_wdata : cmp_buf_a_r;
         compare_value_b_r <= wr_hit(reg_addr, `TWOC_OFS_CMP_B) ? reg_wdata : cmp_buf_b_r;
      end else if (count_tick &&
                   ((upd_at_bottom && at_bottom) || (is_phase && at_top))) begin
         compare_value_a_r <= cmp_buf_a_r;
         compare_value_b_r <= cmp_buf_b_r;
      end
   end

   // Counter with direction for phase correct
   always @(posedge clk) begin
      if (!reset_n) begin
         count_r <= `TWOC_BOTTOM;
         counting_up_r <= 1'b1;
      end else if (wr_cnt) begin
         count_r <= reg_wdata;
      end else if (count_tick && !reserved_mode) begin
         if (is_phase) begin
            if (counting_up_r && at_top) begin
               counting_up_r <= 1'b0;
               count_r <= count_r - 8'h01;
            end else if (!counting_up_r && at_bottom) begin
               counting_up_r <= 1'b1;
               count_r <= count_r + 8'h01;
            end else begin
               count_r <= counting_up_r ? count_r + 8'h01 : count_r - 8'h01;
            end
         end else begin
            counting_up_r <= 1'b1;
            count_r <= at_top ? `TWOC_BOTTOM : count_r + 8'h01;
         end
      end
   end

   // Compare matches, blocked on a tick in the same cycle as a counter write
   always @(posedge clk) begin
      if (!reset_n) begin
         match_a_r <= 1'b0;
         match_b_r <= 1'b0;
      end else begin
         match_a_r <= count_tick && !wr_cnt && (count_r == compare_value_a_r);
         match_b_r <= count_tick && !wr_cnt && (count_r == compare_value_b_r);
      end
   end

   // Sticky overflow flag, set wins over clear-by-writing-one
   always @(posedge clk) begin
      if (!reset_n) begin
         overflow_flag_r <= 1'b0;
         overflow_pulse_r <= 1'b0;
      end else begin
         overflow_pulse_r <= ovf_evt;
         if (ovf_evt)
            overflow_flag_r <= 1'b1;
         else if (wr_hit(reg_addr, `TWOC_OFS_STATUS) && reg_wdata[0])
            overflow_flag_r <= 1'b0;
      end
   end

   // Channel A output
   twoc_wave_chan u_chan_a (
      .clk(clk),
      .reset_n(reset_n),
      .action(chan_a_output_action),
      .is_chan_a(1'b1),
      .mode_hi(wave_mode_high_bit_r),
      .is_pwm(is_pwm),
      .is_fast(is_fast),
      .is_phase(is_phase),
      .match(match_a_r),
      .cmp_is_top(compare_value_a_r == top_val),
      .at_bottom(count_tick && at_bottom && is_fast),
      .at_top(count_tick && at_top),
      .counting_up(counting_up_r),
      .wave_r(compare_out_a),
      .pin_sel_r(compare_out_a_sel)
   );

   // Channel B output
   twoc_wave_chan u_chan_b (
      .clk(clk),
      .reset_n(reset_n),
      .action(chan_b_output_action),
      .is_chan_a(1'b0),
      .mode_hi(wave_mode_high_bit_r),
      .is_pwm(is_pwm),
      .is_fast(is_fast),
      .is_phase(is_phase),
      .match(match_b_r),
      .cmp_is_top(compare_value_b_r == top_val),
      .at_bottom(count_tick && at_bottom && is_fast),
      .at_top(count_tick && at_top),
      .counting_up(counting_up_r),
      .wave_r(compare_out_b),
      .pin_sel_r(compare_out_b_sel)
   );

   // Read mux
   always @* begin
      case (reg_addr)
         `TWOC_OFS_CTRL_A: rdata_nxt = {ctrl_a_r[7:4], 2'b00, ctrl_a_r[1:0]};
         `TWOC_OFS_CTRL_B: rdata_nxt = {4'h0, wave_mode_high_bit_r, 3'h0};
         `TWOC_OFS_CNT: rdata_nxt = count_r;
         `TWOC_OFS_CMP_A: rdata_nxt = cmp_buf_a_r;
         `TWOC_OFS_CMP_B: rdata_nxt = cmp_buf_b_r;
         `TWOC_OFS_STATUS: rdata_nxt = {7'h00, overflow_flag_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Read data one cycle after the strobe
   always @(posedge clk) begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
      else
         reg_rdata <= 8'h00;
   end
endmodule // twoc_top
`default_nettype wire

// ==== twoc_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "twoc_map.vh"
module twoc_top_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic count_tick,
   input wire logic [7:0] reg_rdata,
   input wire logic compare_out_a,
   input wire logic compare_out_a_sel,
   input wire logic compare_out_b,
   input wire logic compare_out_b_sel,
   input wire logic overflow_pulse_r
);
   logic [7:0] sh_a_r;
   logic sh_m_r;
   wire resv = ({sh_m_r, sh_a_r[1:0]} == 3'h4) || ({sh_m_r, sh_a_r[1:0]} == 3'h6);
   // Shadow of the control bits software wrote
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sh_a_r <= 8'h00;
         sh_m_r <= 1'b0;
      end else if (reg_wr && reg_addr == `TWOC_OFS_CTRL_A) begin
         sh_a_r <= reg_wdata;
      end else if (reg_wr && reg_addr == `TWOC_OFS_CTRL_B) begin
         sh_m_r <= reg_wdata[`TWOC_WM_TOP_BIT];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_sel_a_track: assert property (compare_out_a_sel == $past(|sh_a_r[7:6]))
      else $error("pin select A wrong");
   a_sel_b_track: assert property (compare_out_b_sel == $past(|sh_a_r[5:4]))
      else $error("pin select B wrong");
   a_sel_a_cause: assert property ($changed(compare_out_a_sel)
      |-> $past(reg_wr, 2) && $past(reg_addr, 2) == `TWOC_OFS_CTRL_A)
      else $error("pin select A moved without write");
   a_resv_bits_zero: assert property (reg_rd && reg_addr == `TWOC_OFS_CTRL_A
      |=> reg_rdata[3:2] == 2'b00)
      else $error("reserved control bits not zero");
   a_ctrl_readback: assert property (reg_rd && reg_addr == `TWOC_OFS_CTRL_A
      |=> reg_rdata == ($past(sh_a_r) & 8'hf3))
      else $error("control A readback wrong");
   a_mode_hi_back: assert property (reg_rd && reg_addr == `TWOC_OFS_CTRL_B
      |=> reg_rdata[3] == $past(sh_m_r))
      else $error("mode high bit readback wrong");
   a_ovf_after_tick: assert property (overflow_pulse_r
      |-> $past(count_tick) || $past(count_tick, 2))
      else $error("overflow without counter advance");
   a_wave_after_tick: assert property ($changed(compare_out_a)
      |-> $past(count_tick) || $past(count_tick, 2))
      else $error("wave A moved without counter advance");
   a_resv_mode_quiet: assert property ($past(resv, 3) && $past(resv, 2) && $past(resv)
      |-> !overflow_pulse_r && $stable(compare_out_a))
      else $error("activity in reserved mode");
endmodule // twoc_top_chk
bind twoc_top twoc_top_chk twoc_top_chk_inst (.clk(clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .count_tick(count_tick), .reg_rdata(reg_rdata), .compare_out_a(compare_out_a),
   .compare_out_a_sel(compare_out_a_sel), .compare_out_b(compare_out_b),
   .compare_out_b_sel(compare_out_b_sel), .overflow_pulse_r(overflow_pulse_r));
`default_nettype wire

// ==== twoc_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "twoc_map.vh"
module twoc_top_test;
   logic clk, reset_n, reg_wr, reg_rd, count_tick, v;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, rd_val;
   wire [7:0] reg_rdata;
   wire oa, oa_sel, ob, ob_sel, ovf;
   int n_fail = 0, compares = 0, cycles = 0;
   twoc_top twoc_top_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .count_tick(count_tick),
      .reg_rdata(reg_rdata), .compare_out_a(oa), .compare_out_a_sel(oa_sel),
      .compare_out_b(ob), .compare_out_b_sel(ob_sel), .overflow_pulse_r(ovf));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
      chk(rd_val, exp);
   endtask
   // Reset values, read-only bits, pin takeover, reserved mode
   task automatic t_regs;
      rdchk(`TWOC_OFS_CTRL_A, `TWOC_RST_CTRL_A);
      // Pin direction is set by port logic outside, so only the select is seen
      wr(`TWOC_OFS_CTRL_A, 8'hff);
      rdchk(`TWOC_OFS_CTRL_A, 8'hf3);
      chk({6'h00, oa_sel, ob_sel}, 8'h03);
      wr(`TWOC_OFS_CTRL_B, 8'h08);
      rdchk(`TWOC_OFS_CTRL_B, 8'h08);
      wr(`TWOC_OFS_CTRL_A, 8'h00);
      count_tick <= 1'b1;
      idle(20);
      chk({6'h00, oa_sel, ob_sel}, 8'h00);
      rdchk(4'hf, 8'h00);
      wr(`TWOC_OFS_CTRL_B, 8'h00);
   endtask
   // Phase correct, A non-inverting, B inverting; overflow at bottom
   task automatic t_phase;
      wr(`TWOC_OFS_CMP_A, 8'h40);
      wr(`TWOC_OFS_CMP_B, 8'h40);
      wr(`TWOC_OFS_CTRL_A, 8'hb1);
      wr(`TWOC_OFS_STATUS, 8'h01);
      wr(`TWOC_OFS_CNT, 8'h3c);
      idle(10);
      chk({6'h00, oa, ob}, 8'h01);
      idle(390);
      chk({6'h00, oa, ob}, 8'h02);
      rdchk(`TWOC_OFS_STATUS, 8'h00);
      idle(100);
      rdchk(`TWOC_OFS_STATUS, 8'h01);
   endtask
   // Normal mode set, clear, toggle on both channels; overflow points
   task automatic t_nonpwm;
      logic [1:0] codes [4] = '{2'b11, 2'b10, 2'b01, 2'b01};
      logic exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 4; i++) begin
         wr(`TWOC_OFS_CTRL_A, {codes[i], codes[i], 4'h0});
         wr(`TWOC_OFS_CNT, 8'h3c);
         idle(10);
         chk({6'h00, oa, ob}, {6'h00, exps[i], exps[i]});
      end
      wr(`TWOC_OFS_STATUS, 8'h01);
      wr(`TWOC_OFS_CNT, 8'hf0);
      idle(15);
      chk({7'h00, ovf}, 8'h00);
      idle(1);
      chk({7'h00, ovf}, 8'h01);
      idle(14);
      rdchk(`TWOC_OFS_STATUS, 8'h01);
      wr(`TWOC_OFS_CTRL_A, 8'h02);
      wr(`TWOC_OFS_STATUS, 8'h01);
      wr(`TWOC_OFS_CNT, 8'h30);
      idle(30);
      rdchk(`TWOC_OFS_STATUS, 8'h00);
   endtask
   // Fast PWM both polarities, compare at TOP, toggle with high mode bit
   task automatic t_fast;
      wr(`TWOC_OFS_CTRL_A, 8'hb3);
      wr(`TWOC_OFS_CNT, 8'h3c);
      idle(10);
      chk({6'h00, oa, ob}, 8'h01);
      wr(`TWOC_OFS_CNT, 8'hfc);
      idle(10);
      chk({6'h00, oa, ob}, 8'h02);
      wr(`TWOC_OFS_CMP_A, 8'h20);
      wr(`TWOC_OFS_CMP_B, 8'hff);
      wr(`TWOC_OFS_CTRL_A, 8'ha3);
      idle(300);
      repeat (260) begin
         idle(1);
         chk({7'h00, ob}, 8'h01);
      end
      wr(`TWOC_OFS_CTRL_B, 8'h08);
      wr(`TWOC_OFS_CTRL_A, 8'h43);
      wr(`TWOC_OFS_CNT, 8'h10);
      idle(3);
      v = oa;
      idle(20);
      chk({7'h00, oa}, {7'h00, ~v});
   endtask
   initial begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      count_tick = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      t_regs();
      t_phase();
      t_nonpwm();
      t_fast();
      conclude();
   end
endmodule // twoc_top_test
`default_nettype wire

// ==== twoc_wave_chan.v ====
`timescale 1ns/10ps
`default_nettype none
`include "twoc_map.vh"
// One compare channel: output level and pin takeover
module twoc_wave_chan (
   input wire clk,
   input wire reset_n,
   input wire [1:0] action,
   input wire is_chan_a,
   input wire mode_hi,
   input wire is_pwm,
   input wire is_fast,
   input wire is_phase,
   input wire match,
   input wire cmp_is_top,
   input wire at_bottom,
   input wire at_top,
   input wire counting_up,
   output reg wave_r,
   output reg pin_sel_r
);
   reg wave_nxt;
   wire hi_top;
   // Upper action bit with compare at TOP ignores the match
   assign hi_top = action[1] && cmp_is_top;
   // Next level of the compare output
   always @* begin
      wave_nxt = wave_r;
      if (!is_pwm) begin
         if (match) begin
            case (action)
               2'b01: wave_nxt = ~wave_r;
               2'b10: wave_nxt = 1'b0;
               2'b11: wave_nxt = 1'b1;
               default: wave_nxt = wave_r;
            endcase
         end
      end else if (action == 2'b01) begin
         // Toggle only for channel A with high mode bit
         if (is_chan_a && mode_hi && match)
            wave_nxt = ~wave_r;
      end else if (action[1]) begin
         if (is_fast) begin
            if (at_bottom)
               wave_nxt = ~action[0];
            else if (match && !hi_top)
               wave_nxt = action[0];
         end else if (is_phase) begin
            if (hi_top) begin
               if (at_top)
                  wave_nxt = action[0];
            end else if (match) begin
               wave_nxt = counting_up ? action[0] : ~action[0];
            end
         end
      end
   end
   // Output flop and pin takeover select
   always @(posedge clk) begin
      if (!reset_n) begin
         wave_r <= 1'b0;
         pin_sel_r <= 1'b0;
      end else begin
         wave_r <= wave_nxt;
         pin_sel_r <= |action;
      end
   end
endmodule // twoc_wave_chan
`default_nettype wire
